/* File: combine_pkg.sv */
// shared constants, register map and carrier types of the two-tile combine block
package combine_pkg;

    // ------------------------------------------------------------
    // register map (byte address = index * 4)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int NREG = 24;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] IDX_MODE = 5'h00;
    localparam logic [IDX_W-1:0] IDX_PRIM = 5'h01;
    localparam logic [IDX_W-1:0] IDX_DEPTH = 5'h02;
    localparam logic [IDX_W-1:0] IDX_BLEND = 5'h03;
    localparam logic [IDX_W-1:0] IDX_FILL = 5'h04;
    localparam logic [IDX_W-1:0] IDX_TMEM_ADDR = 5'h05;
    localparam logic [IDX_W-1:0] IDX_TMEM_LO = 5'h06;
    localparam logic [IDX_W-1:0] IDX_TMEM_HI = 5'h07;
    localparam logic [IDX_W-1:0] IDX_STATUS = 5'h08;
    localparam logic [IDX_W-1:0] IDX_TILE0 = 5'h10;
    localparam int NTILE = 8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CYC_LSB = 0;
    localparam int ZEN_BIT = 2;
    localparam int ZSRC_BIT = 3;
    localparam int ATEST_BIT = 4;
    localparam int CIFB_BIT = 5;
    localparam int SEL_A_LSB = 8;
    localparam int SEL_B_LSB = 10;
    localparam int SEL_C_LSB = 12;
    localparam int SEL_D_LSB = 14;
    localparam int DRAW_TILE_LSB = 16;
    localparam int LOD_LSB = 8;
    localparam int ALPHA_LSB = 24;
    localparam int BASE_LSB = 0;
    localparam int SHIFT_LSB = 9;
    localparam int LINE_LSB = 13;
    localparam int WR_CNT_LSB = 0;
    localparam int SUP_CNT_LSB = 16;

    localparam int Z_W = 18;
    localparam int TMEM_AW = 9;
    localparam int TMEM_WORDS = 512;
    localparam int TEX_IDX_W = 10;
    localparam logic [8:0] HALF_WEIGHT = 9'h080;
    localparam logic [7:0] CH_MAX = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        CYC_ONE = 2'h0,
        dual_cycle_setting = 2'h1,
        CYC_COPY = 2'h2,
        CYC_FILL = 2'h3
    } cycle_t;
    localparam logic constant_depth_select = 1'b1;
    // operand codes for A, B, D; weight codes for C
    localparam logic [1:0] OP_FIRST = 2'h0;
    localparam logic [1:0] OP_SECOND = 2'h1;
    localparam logic [1:0] OP_ZERO = 2'h2;
    localparam logic [1:0] W_PRIM_ALPHA = 2'h0;
    localparam logic [1:0] W_LOD_FRAC = 2'h1;
    localparam logic [1:0] W_FIRST_ALPHA = 2'h2;

    typedef struct packed {
        logic valid;
        logic [9:0] s;
        logic [9:0] t;
        logic [Z_W-1:0] z;
        logic [Z_W-1:0] mem_z;
        logic rect;
    } pix_in_t;

    typedef struct packed {
        logic valid;
        logic [31:0] color;
        logic [Z_W-1:0] z;
        logic z_en;
        logic cov_en;
    } wr_out_t;

    typedef struct packed {
        logic valid;
        logic [TMEM_AW-1:0] word0;
        logic half0;
        logic [TMEM_AW-1:0] word1;
        logic half1;
        logic [Z_W-1:0] z;
        logic [Z_W-1:0] mem_z;
        logic zact;
    } pipe_t;

endpackage : combine_pkg

/* File: two_tile_combine_zsource.sv */
// two-tile colour combiner, alpha cut-out and depth-source pixel stage with AXI4-Lite registers
`timescale 1ns/1ps

module two_tile_combine_zsource (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic [combine_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [combine_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire combine_pkg::pix_in_t PIX_I,
    output combine_pkg::wr_out_t WR_O
);
    import combine_pkg::*;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NREG-1:0][31:0] regs;
        pipe_t s1;
        pipe_t s2;
        wr_out_t out;
    } state_t;

    state_t st;
    state_t next_st;
    logic [63:0] tmem [TMEM_WORDS];
    logic [63:0] rd0;
    logic [63:0] rd1;
    logic tmem_we;
    logic [TMEM_AW-1:0] tmem_wa;
    logic [63:0] tmem_wd;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rd_mask(input logic [IDX_W-1:0] i);
        if (i >= IDX_TILE0 && i < IDX_TILE0 + 5'(NTILE)) begin
            rd_mask = 32'h001f_ffff;
        end else begin
            unique case (i)
                IDX_MODE: rd_mask = 32'h0007_ff3f;
                IDX_PRIM: rd_mask = 32'hff00_ff00;
                IDX_DEPTH: rd_mask = 32'h0003_ffff;
                IDX_BLEND: rd_mask = 32'h0000_00ff;
                IDX_TMEM_ADDR: rd_mask = 32'h0000_01ff;
                IDX_FILL, IDX_TMEM_LO, IDX_TMEM_HI, IDX_STATUS: rd_mask = 32'hffff_ffff;
                default: rd_mask = 32'h0000_0000;
            endcase
        end
    endfunction : rd_mask

    // texel index inside texture memory: base in 64-bit words, two texels a word
    function automatic logic [TEX_IDX_W-1:0] fetch(input logic [31:0] tile,
                                                  input logic [9:0] s, input logic [9:0] t);
        logic [3:0] sh;
        logic [9:0] ss;
        logic [9:0] ts;
        logic [17:0] row;
        sh = tile[SHIFT_LSB +: 4];
        ss = s >> sh;
        ts = t >> sh;
        row = ts * tile[LINE_LSB +: 8];
        fetch = {tile[BASE_LSB +: TMEM_AW], 1'b0} + row[TEX_IDX_W-1:0] + ss;
    endfunction : fetch

    function automatic logic [7:0] cc(input logic [7:0] a, input logic [7:0] b,
                                      input logic [8:0] c, input logic [7:0] d);
        logic signed [9:0] diff;
        logic signed [19:0] prod;
        logic signed [11:0] sum;
        diff = $signed({2'h0, a}) - $signed({2'h0, b});
        prod = diff * $signed({1'b0, c});
        sum = 12'(prod >>> 8) + $signed({4'h0, d});
        if (sum < 0) begin
            cc = 8'h00;
        end else if (sum > $signed({4'h0, CH_MAX})) begin
            cc = CH_MAX;
        end else begin
            cc = sum[7:0];
        end
    endfunction : cc

    function automatic logic [31:0] pick(input logic [1:0] code, input logic [31:0] t0,
                                         input logic [31:0] t1);
        unique case (code)
            OP_FIRST: pick = t0;
            OP_SECOND: pick = t1;
            OP_ZERO: pick = 32'h0000_0000;
            default: pick = 32'hffff_ffff;
        endcase
    endfunction : pick

    // ------------------------------------------------------------
    // live configuration and combiner datapath
    // ------------------------------------------------------------
    logic [31:0] mode;
    cycle_t cyc;
    logic [2:0] draw_tile;
    logic [31:0] first_tile_sample;
    logic [31:0] second_tile_sample;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] opd;
    logic [8:0] weight;
    logic [31:0] mixed;

    assign mode = st.regs[IDX_MODE];
    assign cyc = cycle_t'(mode[CYC_LSB +: 2]);
    assign draw_tile = mode[DRAW_TILE_LSB +: 3];
    assign first_tile_sample = st.s2.half0 ? rd0[63:32] : rd0[31:0];
    assign second_tile_sample = st.s2.half1 ? rd1[63:32] : rd1[31:0];
    assign opa = pick(mode[SEL_A_LSB +: 2], first_tile_sample, second_tile_sample);
    assign opb = pick(mode[SEL_B_LSB +: 2], first_tile_sample, second_tile_sample);
    assign opd = pick(mode[SEL_D_LSB +: 2], first_tile_sample, second_tile_sample);

    always_comb begin
        unique case (mode[SEL_C_LSB +: 2])
            W_PRIM_ALPHA: weight = {1'b0, st.regs[IDX_PRIM][ALPHA_LSB +: 8]};
            W_LOD_FRAC: weight = {1'b0, st.regs[IDX_PRIM][LOD_LSB +: 8]};
            // full texel alpha maps to a weight of one, not 255/256
            W_FIRST_ALPHA: weight = {1'b0, first_tile_sample[31:24]} +
                                    9'(first_tile_sample[31]);
            default: weight = {1'b0, second_tile_sample[31:24]} +
                              9'(second_tile_sample[31]);
        endcase
    end

    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        assign mixed[8*ch +: 8] = cc(opa[8*ch +: 8], opb[8*ch +: 8], weight,
                                     opd[8*ch +: 8]);
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;
    logic wmapped;
    logic rmapped;
    logic [31:0] bmask;
    logic [31:0] color;
    logic [7:0] cmp_val;
    logic apass;
    logic zpass;
    logic [TEX_IDX_W-1:0] ti0;
    logic [TEX_IDX_W-1:0] ti1;

    assign widx = st.awaddr[IDX_W+1:2];
    assign ridx = S_AXI_ARADDR_I[IDX_W+1:2];
    assign wmapped = !st.awaddr[ADDR_W-1] && (rd_mask(widx) != 32'h0);
    assign rmapped = !S_AXI_ARADDR_I[ADDR_W-1] && (rd_mask(ridx) != 32'h0);
    assign ti0 = fetch(st.regs[IDX_TILE0 + 5'(draw_tile)], PIX_I.s, PIX_I.t);
    assign ti1 = (cyc == dual_cycle_setting) ?
                 fetch(st.regs[IDX_TILE0 + 5'(3'(draw_tile + 3'h1))], PIX_I.s, PIX_I.t) : ti0;
    assign cmp_val = mode[CIFB_BIT] ? color[7:0] : color[31:24];
    assign apass = !mode[ATEST_BIT] || (cmp_val >= st.regs[IDX_BLEND][7:0]);
    assign zpass = !st.s2.zact || (st.s2.z < st.s2.mem_z);

    always_comb begin
        unique case (cyc)
            CYC_FILL: color = st.regs[IDX_FILL];
            CYC_COPY: color = first_tile_sample;
            default: color = mixed;
        endcase
    end

    always_comb begin
        next_st = st;
        tmem_we = 1'b0;
        tmem_wa = st.regs[IDX_TMEM_ADDR][TMEM_AW-1:0];
        tmem_wd = {st.regs[IDX_TMEM_HI], st.regs[IDX_TMEM_LO]};
        bmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            next_st.w_got = 1'b1;
            next_st.wdata = S_AXI_WDATA_I;
            next_st.wstrb = S_AXI_WSTRB_I;
        end
        if (st.bvalid && S_AXI_BREADY_I) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wmapped ? RESP_OKAY : RESP_DECERR;
            if (wmapped && widx != IDX_STATUS) begin
                next_st.regs[widx] = (st.regs[widx] & ~bmask) | (st.wdata & bmask);
            end
            // upper half commits the 64-bit word and steps the word address
            if (wmapped && widx == IDX_TMEM_HI) begin
                tmem_we = 1'b1;
                tmem_wd = {(st.regs[IDX_TMEM_HI] & ~bmask) | (st.wdata & bmask),
                           st.regs[IDX_TMEM_LO]};
                next_st.regs[IDX_TMEM_ADDR] = {23'h0, tmem_wa + 9'h001};
            end
        end
        if (st.rvalid && S_AXI_RREADY_I) begin
            next_st.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = rmapped ? RESP_OKAY : RESP_DECERR;
            next_st.rdata = rmapped ? (st.regs[ridx] & rd_mask(ridx)) : 32'h0;
        end
        // stage 1: addresses, depth snapshot taken at entry so depth writes race nothing
        next_st.s1.valid = PIX_I.valid;
        next_st.s1.word0 = ti0[TEX_IDX_W-1:1];
        next_st.s1.half0 = ti0[0];
        next_st.s1.word1 = ti1[TEX_IDX_W-1:1];
        next_st.s1.half1 = ti1[0];
        next_st.s1.z = (PIX_I.rect || mode[ZSRC_BIT] == constant_depth_select) ?
                       st.regs[IDX_DEPTH][Z_W-1:0] : PIX_I.z;
        next_st.s1.mem_z = PIX_I.mem_z;
        next_st.s1.zact = mode[ZEN_BIT] && (cyc == CYC_ONE || cyc == dual_cycle_setting);
        // stage 2 lines up with the texture memory read data
        next_st.s2 = st.s1;
        // output stage
        next_st.out.valid = st.s2.valid && apass && zpass;
        next_st.out.color = color;
        next_st.out.z = st.s2.z;
        next_st.out.z_en = st.s2.zact;
        next_st.out.cov_en = !mode[CIFB_BIT];
        if (st.s2.valid) begin
            if (apass && zpass) begin
                next_st.regs[IDX_STATUS][WR_CNT_LSB +: 16] =
                    st.regs[IDX_STATUS][WR_CNT_LSB +: 16] + 16'h0001;
            end else begin
                next_st.regs[IDX_STATUS][SUP_CNT_LSB +: 16] =
                    st.regs[IDX_STATUS][SUP_CNT_LSB +: 16] + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // state and texture memory
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // no reset on the memory so it maps onto block RAM
    always_ff @(posedge REF_CLK_I) begin
        if (tmem_we) begin
            tmem[tmem_wa] <= tmem_wd;
        end
        rd0 <= tmem[st.s1.word0];
        rd1 <= tmem[st.s1.word1];
    end

    assign S_AXI_AWREADY_O = !st.aw_got && !st.bvalid;
    assign S_AXI_WREADY_O = !st.w_got && !st.bvalid;
    assign S_AXI_BVALID_O = st.bvalid;
    assign S_AXI_BRESP_O = st.bresp;
    assign S_AXI_ARREADY_O = !st.rvalid;
    assign S_AXI_RVALID_O = st.rvalid;
    assign S_AXI_RDATA_O = st.rdata;
    assign S_AXI_RRESP_O = st.rresp;
    assign WR_O = st.out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic [8:0] avg2;
    logic mid_blend;
    assign avg2 = {1'b0, first_tile_sample[7:0]} + {1'b0, second_tile_sample[7:0]};
    assign mid_blend = st.s2.valid && weight == HALF_WEIGHT &&
                       mode[SEL_A_LSB +: 2] == OP_SECOND && mode[SEL_B_LSB +: 2] == OP_FIRST &&
                       mode[SEL_D_LSB +: 2] == OP_FIRST;

    sequence s_no_depth_modes;
        (cyc == CYC_COPY || cyc == CYC_FILL)[*4];
    endsequence
    sequence s_const_pixel;
        PIX_I.valid && mode[ZSRC_BIT] && !PIX_I.rect;
    endsequence
    sequence s_tmem_commit;
        tmem_we ##1 1'b1;
    endsequence

    a_depth_mode_gate: assert property (s_no_depth_modes |-> !WR_O.z_en)
        else $error("depth test active in copy or fill mode");
    a_const_depth: assert property (s_const_pixel |-> ##3
        (!WR_O.valid || WR_O.z == $past(st.regs[IDX_DEPTH][Z_W-1:0], 3)))
        else $error("constant depth not used");
    a_rect_depth: assert property (PIX_I.valid && PIX_I.rect |-> ##3
        (!WR_O.valid || WR_O.z == $past(st.regs[IDX_DEPTH][Z_W-1:0], 3)))
        else $error("rectangle used pixel depth");
    a_alpha_cut: assert property (st.s2.valid && mode[ATEST_BIT] &&
        cmp_val < st.regs[IDX_BLEND][7:0] |=> !WR_O.valid)
        else $error("pixel below threshold written");
    a_alpha_keep: assert property (st.s2.valid && apass && zpass |=> WR_O.valid)
        else $error("passing pixel dropped");
    a_ci_coverage: assert property (WR_O.valid && $past(mode[CIFB_BIT]) |-> !WR_O.cov_en)
        else $error("coverage stored in colour-index mode");
    a_tmem_step: assert property (s_tmem_commit |->
        st.regs[IDX_TMEM_ADDR][TMEM_AW-1:0] == $past(tmem_wa) + 9'h001)
        else $error("word address did not step");
    a_half_blend: assert property (mid_blend |->
        (({mixed[7:0], 1'b0} >= avg2 - 9'h002) && ({mixed[7:0], 1'b0} <= avg2 + 9'h002)))
        else $error("half weight is not a midpoint blend");
    a_decal_full: assert property (st.s2.valid && mode[SEL_C_LSB +: 2] == W_FIRST_ALPHA &&
        mode[SEL_B_LSB +: 2] == mode[SEL_D_LSB +: 2] &&
        first_tile_sample[31:24] == CH_MAX |-> mixed == opa)
        else $error("full texel alpha did not select its tile");
    a_single_fetch: assert property (PIX_I.valid && cyc == CYC_ONE |=>
        st.s1.word0 == st.s1.word1)
        else $error("second tile fetched in one-cycle mode");
    a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
        else $error("write response dropped");

endmodule : two_tile_combine_zsource

/* File: host_model.sv */
// host model: register-bus master that issues the block's commands
`timescale 1ns/1ps
module host_model (
    input wire logic clk_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    // ------------------------------------------------------------
    // bus cycles: no cycle count assumed, only the bench watchdog ends a wait
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        awaddr_o <= a;
        awvalid_o <= 1'b1;
        wdata_o <= d;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awvalid_o && awready_i) awvalid_o <= 1'b0;
            if (wvalid_o && wready_i) wvalid_o <= 1'b0;
        end while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arvalid_o && arready_i) arvalid_o <= 1'b0;
        end while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask : rd
endmodule : host_model

/* File: tb.sv */
// self-checking bench for the two-tile combine block
`timescale 1ns/1ps
module tb;
    import combine_pkg::*;
    localparam logic [31:0] T0L = 32'hff204080;
    localparam logic [31:0] T0H = 32'h00112200;
    localparam logic [31:0] T1L = 32'h40e0c0a0;
    localparam logic [31:0] T1H = 32'h00aa5500;
    localparam logic [7:0] PASS_D = {OP_FIRST, W_PRIM_ALPHA, OP_ZERO, OP_ZERO};
    localparam logic [7:0] MORPH = {OP_FIRST, W_PRIM_ALPHA, OP_FIRST, OP_SECOND};
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, st0, st1;
    logic [1:0] bresp, rresp;
    pix_in_t pix;
    wr_out_t wr, w;
    int n_mismatch = 0;
    int cmp_count = 0;

    two_tile_combine_zsource i_two_tile_combine_zsource (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .PIX_I(pix), .WR_O(wr)
    );
    host_model i_host_model (
        .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
        .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
        .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
        .rready_o(rready)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] ba(input logic [IDX_W-1:0] i);
        return {1'b0, i, 2'b00};
    endfunction : ba
    function automatic logic [31:0] mode(input logic [1:0] cyc, input logic [3:0] fl,
                                         input logic [7:0] sel);
        return {16'h0, sel, 2'h0, fl, cyc};
    endfunction : mode
    // per byte: (a-b)*c/256 + d, clamped
    function automatic logic [31:0] mix(input logic [31:0] a, b, d, input int c);
        int v;
        for (int i = 0; i < 4; i++) begin
            v = ((int'(a[8*i+:8]) - int'(b[8*i+:8])) * c >>> 8) + int'(d[8*i+:8]);
            mix[8*i+:8] = v < 0 ? 8'h00 : (v > 255 ? 8'hff : v[7:0]);
        end
    endfunction : mix
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rw(input logic [IDX_W-1:0] i, input logic [31:0] d);
        logic [1:0] r;
        i_host_model.wr(ba(i), d, r);
    endtask : rw
    task automatic rr(input logic [IDX_W-1:0] i, output logic [31:0] d);
        logic [1:0] r;
        i_host_model.rd(ba(i), d, r);
    endtask : rr
    task automatic tile(input int k, input logic [8:0] base, input logic [3:0] sh);
        rw(IDX_TILE0 + 5'(k), {11'h0, 8'd2, sh, base});
    endtask : tile
    // pixel taken at the second edge, result stands after 2 more edges
    task automatic px(input logic [9:0] s, input logic [17:0] z, input logic [17:0] mz,
                      input logic rect);
        @(posedge clk);
        pix <= '{1'b1, s, 10'h0, z, mz, rect};
        @(posedge clk);
        pix.valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        w = wr;
    endtask : px
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        for (int k = 0; k < 8; k++) tile(k, 9'(k), 4'(k));
        for (int k = 0; k < 8; k++) begin
            rr(IDX_TILE0 + 5'(k), d);
            chk(d, {11'h0, 8'd2, 4'(k), 9'(k)});
        end
        i_host_model.wr(8'h80, 32'h5a5a5a5a, r);
        chk(r, RESP_DECERR);
        i_host_model.rd(8'h80, d, r);
        chk({r, d[29:0]}, {RESP_DECERR, 30'h0});
    endtask : t_regs
    task automatic t_load;
        rw(IDX_TMEM_ADDR, 32'h0);
        rw(IDX_TMEM_LO, T0L);
        rw(IDX_TMEM_HI, T0H);
        rw(IDX_TMEM_ADDR, 32'h100);
        rw(IDX_TMEM_LO, T1L);
        rw(IDX_TMEM_HI, T1H);
        // tiles are point sampled, so no border ring is loaded
        tile(0, 9'h0, 4'h0);
        tile(1, 9'h100, 4'h0);
    endtask : t_load
    task automatic t_morph;
        rw(IDX_MODE, mode(dual_cycle_setting, 4'h0, MORPH));
        rw(IDX_PRIM, 32'h80000000);
        px(10'd0, 18'd0, 18'd1, 1'b0);
        chk(w.color, mix(T1L, T0L, T0L, 128));
        rw(IDX_MODE, mode(dual_cycle_setting, 4'h0, {MORPH[7:6], W_LOD_FRAC, MORPH[3:0]}));
        rw(IDX_PRIM, 32'h00008000);
        px(10'd0, 18'd0, 18'd1, 1'b0);
        chk(w.color, mix(T1L, T0L, T0L, 128));
        rw(IDX_MODE, mode(dual_cycle_setting, 4'h0,
                          {OP_SECOND, W_FIRST_ALPHA, OP_SECOND, OP_FIRST}));
        px(10'd0, 18'd0, 18'd1, 1'b0);
        chk(w.color, T0L);
        px(10'd1, 18'd0, 18'd1, 1'b0);
        chk(w.color, T1H);
    endtask : t_morph
    task automatic t_shift;
        tile(0, 9'h0, 4'h1);
        rw(IDX_MODE, mode(CYC_ONE, 4'h0, PASS_D));
        px(10'd2, 18'd0, 18'd1, 1'b0);
        chk(w.color, T0H);
        tile(0, 9'h0, 4'h0);
    endtask : t_shift
    task automatic t_alpha;
        rw(IDX_MODE, mode(CYC_ONE, 4'h4, PASS_D));
        rw(IDX_BLEND, 32'h1);
        rr(IDX_STATUS, st0);
        px(10'd0, 18'd0, 18'd1, 1'b0);
        chk({w.valid, w.cov_en}, 2'b11);
        px(10'd1, 18'd0, 18'd1, 1'b0);
        chk(w.valid, 1'b0);
        rr(IDX_STATUS, st1);
        chk(st1, st0 + 32'h00010001);
        // colour-index copy: inert render setting, no filtering
        rw(IDX_MODE, mode(CYC_COPY, 4'hc, PASS_D));
        px(10'd0, 18'd0, 18'd1, 1'b0);
        chk({w.valid, w.cov_en}, 2'b10);
        chk(w.color, T0L);
        px(10'd1, 18'd0, 18'd1, 1'b0);
        chk(w.valid, 1'b0);
    endtask : t_alpha
    task automatic t_depth;
        rw(IDX_DEPTH, 32'd100);
        rw(IDX_MODE, mode(CYC_ONE, 4'h3, PASS_D));
        px(10'd0, 18'd500, 18'd200, 1'b1);
        chk({w.valid, w.z_en, 12'h0, w.z}, {2'b11, 12'h0, 18'd100});
        fork
            px(10'd0, 18'd500, 18'd200, 1'b1);
            rw(IDX_DEPTH, 32'd300);
        join
        chk(w.z, 18'd100);
        px(10'd0, 18'd50, 18'd200, 1'b0);
        chk(w.valid, 1'b0);
        rw(IDX_MODE, mode(CYC_ONE, 4'h1, PASS_D));
        px(10'd0, 18'd50, 18'd200, 1'b0);
        chk({w.valid, 13'h0, w.z}, {1'b1, 13'h0, 18'd50});
        rw(IDX_DEPTH, 32'd100);
        px(10'd0, 18'd500, 18'd200, 1'b1);
        chk({w.valid, 13'h0, w.z}, {1'b1, 13'h0, 18'd100});
        rw(IDX_MODE, mode(CYC_COPY, 4'h1, PASS_D));
        px(10'd0, 18'd500, 18'd200, 1'b0);
        chk({w.valid, w.z_en}, 2'b10);
    endtask : t_depth
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        pix = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_load();
        t_morph();
        t_shift();
        t_alpha();
        t_depth();
        results();
    end
endmodule : tb
